// ==== verilog/bsc_pkg.sv ====
// Purpose: Constants for the bridge system control bits block
// Assumes: One 32-bit register per function, reached at a chosen word address
// Notes:   Bits 31..27 are not implemented and read as zero
`default_nettype none
package bsc_pkg;
    localparam logic [3:0]  REG_ADDR      = 4'h0;
    localparam int unsigned ADDR_W        = 4;
    localparam int unsigned POS_ROUTE     = 26;
    localparam int unsigned POS_PW_FLAG   = 25;
    localparam int unsigned POS_PW_EN     = 24;
    localparam int unsigned POS_RSV_PIN   = 22;
    localparam int unsigned POS_VCC_DIS   = 21;
    localparam int unsigned POS_CARD_DMA_REQUEST_EN   = 19;
    localparam int unsigned POS_CHAN_LO   = 16;
    localparam int unsigned POS_BURST_DN  = 15;
    localparam int unsigned POS_BURST_UP  = 14;
    localparam int unsigned POS_ACTIVE    = 13;
    localparam int unsigned POS_RAIL      = 12;
    localparam int unsigned POS_PWR_BUSY  = 11;
    localparam int unsigned POS_UP_WAIT   = 10;
    localparam int unsigned POS_DN_WAIT   = 9;
    localparam int unsigned POS_INTERROG  = 8;
    localparam int unsigned POS_IDLE_GATE = 6;
    localparam int unsigned POS_ID_WP     = 5;
    localparam int unsigned POS_PAR_REP   = 4;
    localparam int unsigned POS_CDMA      = 3;
    localparam int unsigned POS_CLK_HOLD  = 1;
    localparam int unsigned POS_RING_MUX  = 0;
    localparam logic        RST_RSV_PIN   = 1'b0;
    localparam logic [2:0]  RST_CHAN      = 3'h4;
    localparam logic        RST_BURST_DN  = 1'b1;
    localparam logic        RST_ID_WP     = 1'b1;
    localparam logic        RST_IDLE_GATE = 1'b1;
    localparam logic [2:0]  CHAN_UNUSED   = 3'h4;
    localparam int unsigned CLK_HZ        = 25000000;
    localparam int unsigned UP_DELAY_US   = 100;
    localparam int unsigned DN_DELAY_US   = 100;
    localparam int unsigned UP_DELAY_CYC  = UP_DELAY_US * (CLK_HZ / 1000000);
    localparam int unsigned DN_DELAY_CYC  = DN_DELAY_US * (CLK_HZ / 1000000);
    localparam int unsigned STREAM_BITS   = 12;
    typedef enum logic [1:0] {
        BSC_IDLE   = 2'b00,
        BSC_STREAM = 2'b01,
        BSC_WAIT   = 2'b11
    } bsc_pwr_t;
endpackage
`default_nettype wire

// ==== verilog/bsc_sysctl.sv ====
// Purpose: System control bits 26..0 of a dual-socket card bridge
// Assumes: Both functions share one clock and reset; card events are synchronous
// Notes:   Global bits have one copy; socket bits have one copy per function
//
// Summary of operation
// - Power write interrupt to IRQ2 or status change
// - Power write flag sets; write one clears
// - Enable resets zero; each power write interrupts only while it is set
// - Drive reserved card pins low when enabled and a CardBus card is inserted
// - Supply protection on at zero, off at one
// - Bits 20,7 read zero; bit 12 one
// - Pass card DMA requests only when enabled
// - Channel code picks DMA channel; four unused
// - Downstream read burst enable, resets on
// - Upstream read burst enable, resets off
// - Activity flag sets on access, read clears
// - Sequence busy until stream and delay end
// - Power-up wait until up delay expires
// - Power-down wait until down delay expires
// - Interrogation flag follows interrogation in progress
// - Gate idle card state machine clock
// - Write protect identification registers when set
// - Report card parity errors on SERR
// - Central DMA enables, masks irq pins 7,6
// - Clock hold refuses clock stop requests
// - Ring wins on shared pin unless muxed
//
// The plain strobed port and the register offsets were left to the implementer.
`default_nettype none
`timescale 1ns/100ps
module bsc_sysctl #(
    parameter int unsigned UP_CYC = bsc_pkg::UP_DELAY_CYC,
    parameter int unsigned DN_CYC = bsc_pkg::DN_DELAY_CYC
) (
    input  wire logic                       clk_sys_i,
    input  wire logic                       resetn_i,
    input  wire logic [bsc_pkg::ADDR_W-1:0] addr_i,
    input  wire logic                       func_i,
    input  wire logic [31:0]                wdata_i,
    input  wire logic                       wr_i,
    input  wire logic                       rd_i,
    output logic      [31:0]                rdata_o,
    input  wire logic [1:0]                 power_write_i,
    input  wire logic                       power_up_i,
    input  wire logic [1:0]                 card_access_i,
    input  wire logic [1:0]                 interrog_busy_i,
    input  wire logic [1:0]                 cardbus_inserted_i,
    input  wire logic [1:0]                 card_idle_clk_stopped_i,
    input  wire logic [1:0]                 card_dma_request_i,
    input  wire logic                       card_parity_err_i,
    input  wire logic                       clkrun_stop_req_i,
    input  wire logic                       ring_i,
    input  wire logic                       pme_i,
    input  wire logic [1:0]                 irq_mux_7_6_i,
    output logic                            irq2_o,
    output logic      [1:0]                 card_status_change_o,
    output logic      [1:0]                 reserved_pin_oe_o,
    output logic      [1:0]                 supply_protect_o,
    output logic                            pcpci_dma_req_o,
    output logic      [2:0]                 dma_channel_o,
    output logic                            read_burst_to_card_o,
    output logic                            read_burst_to_host_o,
    output logic      [1:0]                 sm_clk_en_o,
    output logic                            id_write_protect_o,
    output logic                            serr_o,
    output logic      [1:0]                 multiplexed_irq_o,
    output logic                            clkrun_refuse_o,
    output logic                            ring_indicate_output_o,
    output logic                            switch_data_o
);
    // ****************************************
    // Register decode
    // ****************************************
    wire       hit      = (addr_i == bsc_pkg::REG_ADDR);
    wire       wr_hit   = wr_i & hit;
    wire       rd_hit   = rd_i & hit;
    wire [1:0] fsel     = func_i ? 2'b10 : 2'b01;
    wire [1:0] wr_sock  = wr_hit ? fsel : 2'b00;
    wire [1:0] rd_sock  = rd_hit ? fsel : 2'b00;

    // Global copies, shared by both functions
    logic       route_q, pw_en_q, rsv_pin_q, card_dma_request_en_q, burst_dn_q, burst_up_q;
    logic       idle_gate_q, id_wp_q, par_rep_q, cdma_q, clk_hold_q, ring_mux_q;
    logic [2:0] chan_q;
    // Per-socket copies
    logic [1:0] pw_flag_q, vcc_dis_q, active_q;

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            route_q     <= 1'b0;
            pw_en_q     <= 1'b0;
            rsv_pin_q   <= bsc_pkg::RST_RSV_PIN;
            card_dma_request_en_q   <= 1'b0;
            chan_q      <= bsc_pkg::RST_CHAN;
            burst_dn_q  <= bsc_pkg::RST_BURST_DN;
            burst_up_q  <= 1'b0;
            idle_gate_q <= bsc_pkg::RST_IDLE_GATE;
            id_wp_q     <= bsc_pkg::RST_ID_WP;
            par_rep_q   <= 1'b0;
            cdma_q      <= 1'b0;
            clk_hold_q  <= 1'b0;
            ring_mux_q  <= 1'b0;
        end else if (wr_hit) begin
            route_q     <= wdata_i[bsc_pkg::POS_ROUTE];
            pw_en_q     <= wdata_i[bsc_pkg::POS_PW_EN];
            rsv_pin_q   <= wdata_i[bsc_pkg::POS_RSV_PIN];
            card_dma_request_en_q   <= wdata_i[bsc_pkg::POS_CARD_DMA_REQUEST_EN];
            chan_q      <= wdata_i[bsc_pkg::POS_CHAN_LO +: 3];
            burst_dn_q  <= wdata_i[bsc_pkg::POS_BURST_DN];
            burst_up_q  <= wdata_i[bsc_pkg::POS_BURST_UP];
            idle_gate_q <= wdata_i[bsc_pkg::POS_IDLE_GATE];
            id_wp_q     <= wdata_i[bsc_pkg::POS_ID_WP];
            par_rep_q   <= wdata_i[bsc_pkg::POS_PAR_REP];
            cdma_q      <= wdata_i[bsc_pkg::POS_CDMA];
            clk_hold_q  <= wdata_i[bsc_pkg::POS_CLK_HOLD];
            ring_mux_q  <= wdata_i[bsc_pkg::POS_RING_MUX];
        end
    end

    // ****************************************
    // Per-socket flags
    // ****************************************
    // Set wins over the write-one or read clear so no event is lost
    wire [1:0] pw_set   = power_write_i & {2{pw_en_q}};
    wire [1:0] pw_clr   = wr_sock & {2{wdata_i[bsc_pkg::POS_PW_FLAG]}};
    wire [1:0] pw_flag_d = pw_set | (pw_flag_q & ~pw_clr);
    wire [1:0] act_d    = card_access_i | (active_q & ~rd_sock);

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pw_flag_q <= 2'b00;
            vcc_dis_q <= 2'b00;
            active_q  <= 2'b00;
        end else begin
            pw_flag_q <= pw_flag_d;
            active_q  <= act_d;
            if (wr_hit && func_i) begin
                vcc_dis_q[1] <= wdata_i[bsc_pkg::POS_VCC_DIS];
            end
            if (wr_hit && !func_i) begin
                vcc_dis_q[0] <= wdata_i[bsc_pkg::POS_VCC_DIS];
            end
        end
    end

    // ****************************************
    // Power switch sequencer
    // ****************************************
    // One shared switch: a new request during a stream is dropped
    bsc_pkg::bsc_pwr_t st_q;
    logic [15:0] cnt_q;
    logic        dir_up_q, shift_q;
    wire         any_pw    = |power_write_i;
    wire         cnt_done  = (cnt_q == 16'h0000);
    wire [15:0]  up_load   = 16'(UP_CYC - 1);
    wire [15:0]  dn_load   = 16'(DN_CYC - 1);
    wire [15:0]  bit_load  = 16'(bsc_pkg::STREAM_BITS - 1);

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q     <= bsc_pkg::BSC_IDLE;
            cnt_q    <= 16'h0000;
            dir_up_q <= 1'b0;
            shift_q  <= 1'b0;
        end else begin
            unique case (st_q)
                bsc_pkg::BSC_IDLE: begin
                    shift_q <= 1'b0;
                    if (any_pw) begin
                        st_q     <= bsc_pkg::BSC_STREAM;
                        cnt_q    <= bit_load;
                        dir_up_q <= power_up_i;
                    end
                end
                bsc_pkg::BSC_STREAM: begin
                    shift_q <= ~shift_q;
                    if (cnt_done) begin
                        st_q  <= bsc_pkg::BSC_WAIT;
                        cnt_q <= dir_up_q ? up_load : dn_load;
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                bsc_pkg::BSC_WAIT: begin
                    shift_q <= 1'b0;
                    if (cnt_done) begin
                        st_q <= bsc_pkg::BSC_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                default: begin
                    st_q <= bsc_pkg::BSC_IDLE;
                end
            endcase
        end
    end

    wire pwr_busy = (st_q != bsc_pkg::BSC_IDLE);
    wire up_wait  = (st_q == bsc_pkg::BSC_WAIT) & dir_up_q;
    wire dn_wait  = (st_q == bsc_pkg::BSC_WAIT) & ~dir_up_q;

    // ****************************************
    // Read data
    // ****************************************
    wire [1:0] rd_bit_idx = fsel;
    wire       s_flag  = |(pw_flag_q & rd_bit_idx);
    wire       s_vcc   = |(vcc_dis_q & rd_bit_idx);
    wire       s_act   = |(active_q & rd_bit_idx);
    wire       s_intg  = |(interrog_busy_i & rd_bit_idx);
    wire [31:0] reg_val = {5'h00, route_q, s_flag, pw_en_q, 1'b0, rsv_pin_q, s_vcc,
                           1'b0, card_dma_request_en_q, chan_q, burst_dn_q, burst_up_q, s_act,
                           1'b1, pwr_busy, up_wait, dn_wait, s_intg, 1'b0,
                           idle_gate_q, id_wp_q, par_rep_q, cdma_q, 1'b0,
                           clk_hold_q, ring_mux_q};
    wire [31:0] rdata_d = rd_hit ? reg_val : 32'h0000_0000;

    // ****************************************
    // Outputs
    // ****************************************
    wire [1:0] pw_evt = pw_set;
    wire       dma_d  = card_dma_request_en_q & (|card_dma_request_i)
                        & (chan_q != bsc_pkg::CHAN_UNUSED);
    wire       ring_d = ring_mux_q ? pme_i : (ring_i | pme_i);
    wire [1:0] gate_d = ~({2{idle_gate_q}} & cardbus_inserted_i
                          & card_idle_clk_stopped_i);

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o                <= 32'h0000_0000;
            irq2_o                 <= 1'b0;
            card_status_change_o   <= 2'b00;
            reserved_pin_oe_o      <= 2'b00;
            supply_protect_o       <= 2'b11;
            pcpci_dma_req_o        <= 1'b0;
            dma_channel_o          <= bsc_pkg::RST_CHAN;
            read_burst_to_card_o   <= bsc_pkg::RST_BURST_DN;
            read_burst_to_host_o   <= 1'b0;
            sm_clk_en_o            <= 2'b11;
            id_write_protect_o     <= bsc_pkg::RST_ID_WP;
            serr_o                 <= 1'b0;
            multiplexed_irq_o      <= 2'b00;
            clkrun_refuse_o        <= 1'b0;
            ring_indicate_output_o <= 1'b0;
            switch_data_o          <= 1'b0;
        end else begin
            rdata_o                <= rdata_d;
            irq2_o                 <= (|pw_evt) & ~route_q;
            card_status_change_o   <= pw_evt & {2{route_q}};
            reserved_pin_oe_o      <= {2{rsv_pin_q}} & cardbus_inserted_i;
            supply_protect_o       <= ~vcc_dis_q;
            pcpci_dma_req_o        <= dma_d & cdma_q;
            dma_channel_o          <= chan_q;
            read_burst_to_card_o   <= burst_dn_q;
            read_burst_to_host_o   <= burst_up_q;
            sm_clk_en_o            <= gate_d;
            id_write_protect_o     <= id_wp_q;
            serr_o                 <= card_parity_err_i & par_rep_q;
            multiplexed_irq_o      <= irq_mux_7_6_i & {2{~cdma_q}};
            clkrun_refuse_o        <= clkrun_stop_req_i & clk_hold_q;
            ring_indicate_output_o <= ring_d;
            switch_data_o          <= shift_q;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_rail_bit: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        rd_hit |=> rdata_o[bsc_pkg::POS_RAIL] && !rdata_o[7] && !rdata_o[20])
        else $error("reserved bits wrong");
    a_irq2_route: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (|power_write_i && pw_en_q && !route_q) |=> irq2_o)
        else $error("irq2 missing");
    a_csc_route: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (power_write_i[0] && pw_en_q && route_q) |=> card_status_change_o[0] && !irq2_o)
        else $error("status change missing");
    a_flag_set: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (power_write_i[0] && pw_en_q) |=> pw_flag_q[0])
        else $error("flag not set");
    a_act_clear: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (rd_hit && !func_i && !card_access_i[0]) |=> !active_q[0])
        else $error("activity not cleared");
    a_busy_start: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (!pwr_busy && any_pw) |=> pwr_busy [*8])
        else $error("sequence not busy");
    a_wait_kind: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !(up_wait && dn_wait))
        else $error("both waits set");
    a_wait_end: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        $fell(dn_wait) |-> !pwr_busy)
        else $error("busy after wait");
    a_ring_pri: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (ring_i && !ring_mux_q) |=> ring_indicate_output_o)
        else $error("ring lost");
    a_clk_hold: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (clkrun_stop_req_i && clk_hold_q) |=> clkrun_refuse_o)
        else $error("clock stop allowed");
    a_dma_gate: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !card_dma_request_en_q |=> !pcpci_dma_req_o)
        else $error("dma request passed while disabled");
    a_irq_mask: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        cdma_q |=> (multiplexed_irq_o == 2'b00))
        else $error("irq pins not masked");
    a_clk_gate: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (idle_gate_q && cardbus_inserted_i[0] && card_idle_clk_stopped_i[0])
        |=> !sm_clk_en_o[0])
        else $error("idle clock not gated");
    a_parity_off: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !par_rep_q |=> !serr_o)
        else $error("parity reported while off");
    a_rsv_drive: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (rsv_pin_q && cardbus_inserted_i[1]) |=> reserved_pin_oe_o[1])
        else $error("reserved pins not driven");
    a_intg_read: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (rd_hit && func_i) |=> (rdata_o[bsc_pkg::POS_INTERROG] == $past(interrog_busy_i[1])))
        else $error("interrogation bit wrong");
    a_flag_clear: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (wr_hit && !func_i && wdata_i[bsc_pkg::POS_PW_FLAG] && !power_write_i[0])
        |=> !pw_flag_q[0])
        else $error("flag not cleared");
    a_supply_prot: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !vcc_dis_q[1] |=> supply_protect_o[1])
        else $error("supply protection off");
    c_dma_fwd: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
        pcpci_dma_req_o);
    c_act_set: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
        $rose(active_q[0]));
    c_power_up: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
        $rose(up_wait));
    c_power_dn: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
        $rose(dn_wait));
    c_flag_clr: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
        $fell(pw_flag_q[1]));
endmodule
`default_nettype wire

// ==== verif/bridge_system_control_bits_test.sv ====
// Purpose: Self-checking bench for the system control bits block
// Assumes: Settling delays shortened to 8 cycles through the parameters
// Notes:   The bench drives every port itself; assertions live in the design
`default_nettype none
`timescale 1ns/100ps
module bridge_system_control_bits_test;
    // ************************************************************
    // Signals
    // ************************************************************
    localparam int unsigned DLY = 8;
    logic        clk_sys_i, resetn_i, func_i, wr_i, rd_i, power_up_i;
    logic [3:0]  addr_i;
    logic [31:0] wdata_i, rdata_o, v;
    logic [1:0]  power_write_i, card_access_i, interrog_busy_i, cardbus_inserted_i;
    logic [1:0]  card_idle_clk_stopped_i, card_dma_request_i, irq_mux_7_6_i;
    logic        card_parity_err_i, clkrun_stop_req_i, ring_i, pme_i;
    logic        irq2_o, pcpci_dma_req_o, read_burst_to_card_o, read_burst_to_host_o;
    logic        id_write_protect_o, serr_o, clkrun_refuse_o, ring_indicate_output_o;
    logic        switch_data_o;
    logic [1:0]  card_status_change_o, reserved_pin_oe_o, supply_protect_o, sm_clk_en_o;
    logic [1:0]  multiplexed_irq_o;
    logic [2:0]  dma_channel_o;
    logic [17:0] outs;
    int          error_cnt, num_checks;
    assign outs = {reserved_pin_oe_o, supply_protect_o, pcpci_dma_req_o, dma_channel_o,
                   read_burst_to_card_o, read_burst_to_host_o, sm_clk_en_o,
                   id_write_protect_o, serr_o, multiplexed_irq_o, clkrun_refuse_o,
                   ring_indicate_output_o};
    bsc_sysctl #(.UP_CYC(DLY), .DN_CYC(DLY)) dut (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .addr_i(addr_i), .func_i(func_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .power_write_i(power_write_i), .power_up_i(power_up_i),
        .card_access_i(card_access_i), .interrog_busy_i(interrog_busy_i),
        .cardbus_inserted_i(cardbus_inserted_i),
        .card_idle_clk_stopped_i(card_idle_clk_stopped_i),
        .card_dma_request_i(card_dma_request_i), .card_parity_err_i(card_parity_err_i),
        .clkrun_stop_req_i(clkrun_stop_req_i), .ring_i(ring_i), .pme_i(pme_i),
        .irq_mux_7_6_i(irq_mux_7_6_i), .irq2_o(irq2_o),
        .card_status_change_o(card_status_change_o),
        .reserved_pin_oe_o(reserved_pin_oe_o), .supply_protect_o(supply_protect_o),
        .pcpci_dma_req_o(pcpci_dma_req_o), .dma_channel_o(dma_channel_o),
        .read_burst_to_card_o(read_burst_to_card_o),
        .read_burst_to_host_o(read_burst_to_host_o), .sm_clk_en_o(sm_clk_en_o),
        .id_write_protect_o(id_write_protect_o), .serr_o(serr_o),
        .multiplexed_irq_o(multiplexed_irq_o), .clkrun_refuse_o(clkrun_refuse_o),
        .ring_indicate_output_o(ring_indicate_output_o), .switch_data_o(switch_data_o));
    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic f, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        wr_i <= 1'b1; func_i <= f; addr_i <= a; wdata_i <= d;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic f, input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys_i);
        rd_i <= 1'b1; func_i <= f; addr_i <= a;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        @(negedge clk_sys_i);
        d = rdata_o;
    endtask
    task automatic outs_are(input logic [17:0] exp);
        repeat (3) @(negedge clk_sys_i);
        chk({14'h0, outs}, {14'h0, exp});
    endtask
    // Pulses a power write, then reads the socket copy every cycle for 40 cycles
    task automatic pw_seq(input logic s, input logic up, input logic [1:0] irq_exp,
                          input logic [1:0] flag_exp);
        int busy, upw, dnw, tog, flag;
        logic [1:0] irq;
        logic last;
        busy = 0; upw = 0; dnw = 0; tog = 0; flag = 0;
        @(posedge clk_sys_i);
        power_write_i <= s ? 2'b10 : 2'b01; power_up_i <= up;
        rd_i <= 1'b1; func_i <= s; addr_i <= bsc_pkg::REG_ADDR;
        @(posedge clk_sys_i);
        power_write_i <= 2'b00;
        @(negedge clk_sys_i);
        irq = {irq2_o, card_status_change_o[s]};
        last = switch_data_o;
        repeat (40) begin
            busy += rdata_o[11]; upw += rdata_o[10]; dnw += rdata_o[9];
            flag |= rdata_o[25]; tog += (switch_data_o !== last); last = switch_data_o;
            @(negedge clk_sys_i);
        end
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        chk(irq, irq_exp);
        chk(flag, flag_exp);
        chk(busy, bsc_pkg::STREAM_BITS + DLY);
        chk({upw[15:0], dnw[15:0]}, up ? {16'(DLY), 16'h0} : {16'h0, 16'(DLY)});
        chk(tog > 0, 1);
    endtask
    task automatic done(input string name);
        $display("test %s finished", name);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ************************************************************
    // Clock, watchdog and tests
    // ************************************************************
    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        #(20000 * 40);
        error_cnt++;
        end_sim;
    end
    initial begin
        error_cnt = 0; num_checks = 0;
        resetn_i = 1'b0; func_i = 1'b0; wr_i = 1'b0; rd_i = 1'b0; addr_i = 4'h0;
        wdata_i = 32'h0; power_write_i = 2'h0; power_up_i = 1'b0; card_access_i = 2'h0;
        interrog_busy_i = 2'h0; cardbus_inserted_i = 2'h0; card_idle_clk_stopped_i = 2'h0;
        card_dma_request_i = 2'h0; card_parity_err_i = 1'b0; clkrun_stop_req_i = 1'b0;
        ring_i = 1'b0; pme_i = 1'b0; irq_mux_7_6_i = 2'h0;
        repeat (8) @(posedge clk_sys_i);
        chk({14'h0, outs}, 32'h0000_d2e0);
        resetn_i <= 1'b1;
        for (int f = 0; f < 2; f++) begin
            rd(f[0], bsc_pkg::REG_ADDR, v);
            chk(v, 32'h0004_9060);
        end
        wr(1'b0, 4'h3, 32'hffff_ffff);
        rd(1'b0, 4'h3, v);
        chk(v, 32'h0);
        rd(1'b0, bsc_pkg::REG_ADDR, v);
        chk(v, 32'h0004_9060);
        done("reset and unmapped");
        cardbus_inserted_i <= 2'b11; card_idle_clk_stopped_i <= 2'b11;
        card_dma_request_i <= 2'b11; card_parity_err_i <= 1'b1; clkrun_stop_req_i <= 1'b1;
        ring_i <= 1'b1; irq_mux_7_6_i <= 2'b11;
        wr(1'b0, bsc_pkg::REG_ADDR, 32'hffff_ffff);
        rd(1'b1, bsc_pkg::REG_ADDR, v);
        chk(v & 32'h0500_c07b, 32'h0500_c07b);
        wr(1'b1, bsc_pkg::REG_ADDR, 32'hffff_ffff);
        rd(1'b0, bsc_pkg::REG_ADDR, v);
        chk(v, 32'h056f_d07b);
        outs_are(18'h33f32);
        wr(1'b0, bsc_pkg::REG_ADDR, 32'h0);
        wr(1'b1, bsc_pkg::REG_ADDR, 32'h0);
        outs_are(18'h0c0cd);
        done("control outputs");
        pw_seq(1'b0, 1'b1, 2'b00, 2'b00);
        wr(1'b0, bsc_pkg::REG_ADDR, 32'h0100_0000);
        pw_seq(1'b0, 1'b1, 2'b10, 2'b01);
        wr(1'b0, bsc_pkg::REG_ADDR, 32'h0300_0000);
        rd(1'b0, bsc_pkg::REG_ADDR, v);
        chk(v[25], 1'b0);
        wr(1'b0, bsc_pkg::REG_ADDR, 32'h0500_0000);
        pw_seq(1'b1, 1'b0, 2'b01, 2'b01);
        done("power write");
        @(posedge clk_sys_i);
        card_access_i <= 2'b01; interrog_busy_i <= 2'b10;
        @(posedge clk_sys_i);
        card_access_i <= 2'b00;
        rd(1'b0, bsc_pkg::REG_ADDR, v);
        chk(v[13:8] & 6'h21, 6'h20);
        rd(1'b0, bsc_pkg::REG_ADDR, v);
        chk(v[13], 1'b0);
        rd(1'b1, bsc_pkg::REG_ADDR, v);
        chk(v[13:8] & 6'h21, 6'h01);
        @(posedge clk_sys_i);
        interrog_busy_i <= 2'b00;
        rd(1'b1, bsc_pkg::REG_ADDR, v);
        chk(v[8], 1'b0);
        done("activity and interrogation");
        end_sim;
    end
endmodule
`default_nettype wire
